// File: rtl/bbl_move_unit.sv
// Execution unit for byte_move and bit_move with its register file
//
// What this block does
// - byte_move copies source, source stays, four or six cycles
// - Immediate into working or full register
// - Immediate into pointer-addressed register, pointer kept
// - Full register and indirect full register moves
// - Working-register indirect loads both ways, four cycles
// - Indexed address is offset plus working register
// - bit_move copies one bit either way
// - Second byte: register, bit index, direction
`timescale 1ns/1ps
`default_nettype none
module bbl_move_unit
  import bbl_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_data,
  output logic            byte_ready_ff,
  output logic            done_ff,
  input  wire logic [3:0] work_base,
  input  wire logic       flags_we,
  input  wire logic [7:0] flags_wdata,
  output logic [7:0]      flags_ff,
  input  wire logic       ext_we,
  input  wire logic [7:0] ext_addr,
  input  wire logic [7:0] ext_wdata,
  output logic [7:0]      ext_rdata_ff
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    bbl_state_t st;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [1:0] got;
    logic [2:0] cnt;
    logic       ready;
    logic       done;
    logic [7:0] flags;
    logic [7:0] rdata;
  } bbl_ctl_t;

  bbl_ctl_t   cur_ff;
  bbl_ctl_t   nxt_cur;
  logic [7:0] regs [256];

  bbl_kind_t  kind;
  logic [1:0] len;
  logic [2:0] cycles;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  bbl_decode u_dec (
    .opcode (cur_ff.op),
    .kind   (kind),
    .len    (len),
    .cycles (cycles)
  );

  // ****************************************
  // Operand forming
  // ****************************************
  logic [7:0] w_hi_op;
  logic [7:0] w_hi_b1;
  logic [7:0] w_lo_b1;
  logic [7:0] idx_addr;
  logic [2:0] bit_idx;
  logic [7:0] bit_reg;
  logic [7:0] bit_work;

  assign w_hi_op  = {work_base, cur_ff.op[7:4]};
  assign w_hi_b1  = {work_base, cur_ff.b1[7:4]};
  assign w_lo_b1  = {work_base, cur_ff.b1[3:0]};
  assign idx_addr = cur_ff.b2 + regs[w_lo_b1];
  assign bit_idx  = cur_ff.b1[3:1];
  assign bit_reg  = regs[cur_ff.b2];
  assign bit_work = regs[w_hi_b1];

  always_comb begin
    wr_addr = 8'h00;
    wr_data = 8'h00;
    case (kind)
      BBL_K_W_IMM: begin
        wr_addr = w_hi_op;
        wr_data = cur_ff.b1;
      end
      BBL_K_W_R: begin
        wr_addr = w_hi_op;
        wr_data = regs[cur_ff.b1];
      end
      BBL_K_R_W: begin
        wr_addr = cur_ff.b1;
        wr_data = regs[w_hi_op];
      end
      BBL_K_W_IW: begin
        wr_addr = w_hi_b1;
        wr_data = regs[regs[w_lo_b1]];
      end
      BBL_K_IW_W: begin
        wr_addr = regs[w_hi_b1];
        wr_data = regs[w_lo_b1];
      end
      BBL_K_R_R: begin
        wr_addr = cur_ff.b2;
        wr_data = regs[cur_ff.b1];
      end
      BBL_K_R_PR: begin
        wr_addr = cur_ff.b2;
        wr_data = regs[regs[cur_ff.b1]];
      end
      BBL_K_R_IMM: begin
        wr_addr = cur_ff.b1;
        wr_data = cur_ff.b2;
      end
      BBL_K_PR_IMM: begin
        wr_addr = regs[cur_ff.b1];
        wr_data = cur_ff.b2;
      end
      BBL_K_PR_R: begin
        wr_addr = regs[cur_ff.b2];
        wr_data = regs[cur_ff.b1];
      end
      BBL_K_W_X: begin
        wr_addr = w_hi_b1;
        wr_data = regs[idx_addr];
      end
      BBL_K_X_W: begin
        wr_addr = idx_addr;
        wr_data = regs[w_hi_b1];
      end
      BBL_K_BIT: begin
        // Only the targeted bit changes, the rest is read back unchanged
        if (cur_ff.b1[0]) begin
          wr_addr = cur_ff.b2;
          wr_data = bit_reg;
          wr_data[bit_idx] = bit_work[0];
        end else begin
          wr_addr = w_hi_b1;
          wr_data = {bit_work[7:1], bit_reg[bit_idx]};
        end
      end
      default: begin
        wr_addr = 8'h00;
        wr_data = 8'h00;
      end
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  logic need_byte;
  logic stall;
  logic fin;

  assign need_byte = (cur_ff.st == BBL_FETCH) && (cur_ff.got < len);
  assign stall     = need_byte && !byte_valid;
  assign fin       = (cur_ff.st == BBL_FETCH) && !stall
                     && (cur_ff.cnt == cycles - 3'h1);
  assign wr_en     = fin && (kind != BBL_K_NONE);

  always_comb begin
    nxt_cur       = cur_ff;
    nxt_cur.done  = 1'b0;
    nxt_cur.rdata = regs[ext_addr];
    // Flags belong to other units; moves never write them
    if (flags_we) begin
      nxt_cur.flags = flags_wdata;
    end
    case (cur_ff.st)
      BBL_IDLE: begin
        if (byte_valid) begin
          nxt_cur.op  = byte_data;
          nxt_cur.got = 2'h1;
          nxt_cur.cnt = 3'h1;
          nxt_cur.st  = BBL_FETCH;
        end
      end
      BBL_FETCH: begin
        if (need_byte && byte_valid) begin
          if (cur_ff.got == 2'h1) begin
            nxt_cur.b1 = byte_data;
          end else begin
            nxt_cur.b2 = byte_data;
          end
          nxt_cur.got = cur_ff.got + 2'h1;
        end
        // Unknown opcode is dropped after one cycle, no write
        if (kind == BBL_K_NONE) begin
          nxt_cur.st = BBL_IDLE;
        end else if (fin) begin
          nxt_cur.st   = BBL_IDLE;
          nxt_cur.done = 1'b1;
        end else if (!stall) begin
          nxt_cur.cnt = cur_ff.cnt + 3'h1;
        end
      end
      default: nxt_cur.st = BBL_IDLE;
    endcase
    // Ready is registered, so look at where the sequencer goes next
    nxt_cur.ready = (nxt_cur.st == BBL_IDLE)
                    || (nxt_cur.got < len && nxt_cur.op == cur_ff.op);
    if (nxt_cur.st == BBL_FETCH && cur_ff.st == BBL_IDLE) begin
      nxt_cur.ready = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cur_ff <= '{st: BBL_IDLE, op: 8'h00, b1: 8'h00, b2: 8'h00, got: 2'h0,
                  cnt: 3'h0, ready: 1'b1, done: 1'b0, flags: FLAGS_RST,
                  rdata: 8'h00};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Register file has no reset; moves take priority over the side port
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      regs[wr_addr] <= wr_data;
    end else if (ext_we) begin
      regs[ext_addr] <= ext_wdata;
    end
  end

  assign byte_ready_ff = cur_ff.ready;
  assign done_ff       = cur_ff.done;
  assign flags_ff      = cur_ff.flags;
  assign ext_rdata_ff  = cur_ff.rdata;

  // ****************************************
  // Checks
  // ****************************************
  a_short_cycles: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && len == LEN_2 |-> cur_ff.cnt == 3'h3)
    else $error("two-byte move not finishing in its fourth cycle");

  a_long_cycles: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && len == LEN_3 |-> cur_ff.cnt == 3'h5)
    else $error("three-byte move not finishing in its sixth cycle");

  a_done_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en |=> done_ff ##1 !done_ff)
    else $error("done pulse missing or too long");

  a_imm_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && kind == BBL_K_R_IMM |=> regs[$past(cur_ff.b1)] == $past(cur_ff.b2))
    else $error("immediate not stored in full register");

  a_ptr_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && kind == BBL_K_PR_IMM && regs[cur_ff.b1] != cur_ff.b1
    |=> regs[$past(cur_ff.b1)] == $past(regs[cur_ff.b1]))
    else $error("pointer register changed by indirect store");

  a_windir_src: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && kind == BBL_K_W_IW |-> wr_data == regs[regs[w_lo_b1]]
    && wr_addr == {work_base, cur_ff.b1[7:4]})
    else $error("working indirect load picked wrong operand");

  a_index_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && kind == BBL_K_X_W |-> wr_addr == 8'(cur_ff.b2 + regs[w_lo_b1]))
    else $error("indexed destination address wrong");

  a_bit_other: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && kind == BBL_K_BIT && cur_ff.b1[0]
    |-> ((wr_data ^ bit_reg) & ~(8'h01 << cur_ff.b1[3:1])) == 8'h00)
    else $error("bit_move disturbed other destination bits");

  a_bit_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && kind == BBL_K_BIT && !cur_ff.b1[0]
    |-> wr_data[0] == regs[cur_ff.b2][cur_ff.b1[3:1]])
    else $error("bit_move direction zero took wrong bit");

  a_flags_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !flags_we |=> $stable(flags_ff))
    else $error("flags changed without a flag write");

endmodule
`default_nettype wire

// File: rtl/bbl_pkg.sv
// Constants and types shared by the byte and bit move execution unit
package bbl_pkg;

  // ****************************************
  // Opcodes (exact byte values)
  // ****************************************
  localparam logic [7:0] OP_CP_RR   = 8'hE4; // full reg <- full reg
  localparam logic [7:0] OP_CP_RIR  = 8'hE5; // full reg <- @full reg
  localparam logic [7:0] OP_CP_RIM  = 8'hE6; // full reg <- immediate
  localparam logic [7:0] OP_CP_IRIM = 8'hD6; // @full reg <- immediate
  localparam logic [7:0] OP_CP_IRR  = 8'hF5; // @full reg <- full reg
  localparam logic [7:0] OP_CP_WIW  = 8'hC7; // work <- @work
  localparam logic [7:0] OP_CP_IWW  = 8'hD7; // @work <- work
  localparam logic [7:0] OP_CP_WX   = 8'h87; // work <- indexed
  localparam logic [7:0] OP_CP_XW   = 8'h97; // indexed <- work
  localparam logic [7:0] OP_BIT     = 8'h47; // bit_move, both directions

  // ****************************************
  // Low-nibble opcodes, high nibble names the working register
  // ****************************************
  localparam logic [3:0] NIB_W_R  = 4'h8;
  localparam logic [3:0] NIB_R_W  = 4'h9;
  localparam logic [3:0] NIB_W_IMM = 4'hC;

  // ****************************************
  // Lengths and cycle counts
  // ****************************************
  localparam logic [1:0] LEN_2   = 2'h2;
  localparam logic [1:0] LEN_3   = 2'h3;
  localparam logic [2:0] CYC_4   = 3'h4;
  localparam logic [2:0] CYC_6   = 3'h6;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  typedef enum logic [3:0] {
    BBL_K_NONE   = 4'h0,
    BBL_K_W_IMM  = 4'h1,
    BBL_K_W_R    = 4'h2,
    BBL_K_R_W    = 4'h3,
    BBL_K_W_IW   = 4'h4,
    BBL_K_IW_W   = 4'h5,
    BBL_K_R_R    = 4'h6,
    BBL_K_R_PR   = 4'h7,
    BBL_K_R_IMM  = 4'h8,
    BBL_K_PR_IMM = 4'h9,
    BBL_K_PR_R   = 4'hA,
    BBL_K_W_X    = 4'hB,
    BBL_K_X_W    = 4'hC,
    BBL_K_BIT    = 4'hD
  } bbl_kind_t;

  typedef enum logic [1:0] {
    BBL_IDLE  = 2'h0,
    BBL_FETCH = 2'h1
  } bbl_state_t;

endpackage

// File: rtl/bbl_decode.sv
// Opcode decoder: form, length and cycle count of one move opcode
`timescale 1ns/1ps
`default_nettype none
module bbl_decode
  import bbl_pkg::*;
(
  input  wire logic [7:0] opcode,
  output bbl_kind_t       kind,
  output logic [1:0]      len,
  output logic [2:0]      cycles
);

  always_comb begin
    kind   = BBL_K_NONE;
    len    = LEN_3;
    cycles = CYC_6;
    case (opcode[3:0])
      NIB_W_IMM: kind = BBL_K_W_IMM;
      NIB_W_R:  kind = BBL_K_W_R;
      NIB_R_W:  kind = BBL_K_R_W;
      default:  kind = BBL_K_NONE;
    endcase
    case (opcode)
      OP_CP_WIW:  kind = BBL_K_W_IW;
      OP_CP_IWW:  kind = BBL_K_IW_W;
      OP_CP_RR:   kind = BBL_K_R_R;
      OP_CP_RIR:  kind = BBL_K_R_PR;
      OP_CP_RIM:  kind = BBL_K_R_IMM;
      OP_CP_IRIM: kind = BBL_K_PR_IMM;
      OP_CP_IRR:  kind = BBL_K_PR_R;
      OP_CP_WX:   kind = BBL_K_W_X;
      OP_CP_XW:   kind = BBL_K_X_W;
      OP_BIT:     kind = BBL_K_BIT;
      default:    kind = kind;
    endcase
    // Two-byte, four-cycle forms
    if (kind inside {BBL_K_W_IMM, BBL_K_W_R, BBL_K_R_W, BBL_K_W_IW, BBL_K_IW_W}) begin
      len    = LEN_2;
      cycles = CYC_4;
    end
  end

endmodule
`default_nettype wire

// File: sim/bbl_move_unit_test.sv
// Self-checking testbench for the byte and bit move execution unit
`timescale 1ns/1ps
`default_nettype none
module bbl_move_unit_test;
  import bbl_pkg::*;
  logic       ref_clk;
  logic       rst_n;
  logic       byte_valid;
  logic [7:0] byte_data;
  logic       byte_ready_ff;
  logic       done_ff;
  logic [3:0] work_base;
  logic       flags_we;
  logic [7:0] flags_wdata;
  logic [7:0] flags_ff;
  logic       ext_we;
  logic [7:0] ext_addr;
  logic [7:0] ext_wdata;
  logic [7:0] ext_rdata_ff;
  int         err_total;
  int         total_checks;
  int         cyc_cnt;

  bbl_move_unit i_dut (
    .ref_clk      (ref_clk),
    .rst_n        (rst_n),
    .byte_valid   (byte_valid),
    .byte_data    (byte_data),
    .byte_ready_ff(byte_ready_ff),
    .done_ff      (done_ff),
    .work_base    (work_base),
    .flags_we     (flags_we),
    .flags_wdata  (flags_wdata),
    .flags_ff     (flags_ff),
    .ext_we       (ext_we),
    .ext_addr     (ext_addr),
    .ext_wdata    (ext_wdata),
    .ext_rdata_ff (ext_rdata_ff)
  );

  // ****************************************
  // Clock and hang guard
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Whole run is under two hundred cycles; ceiling leaves ample margin
  always @(posedge ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      err_total++;
      give_verdict();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    ext_we    <= 1'b1;
    ext_addr  <= a;
    ext_wdata <= d;
    @(posedge ref_clk);
    ext_we    <= 1'b0;
  endtask

  // Side-port read lags the address by one edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    ext_addr <= a;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk8($sformatf("reg_%h", a), exp, ext_rdata_ff);
  endtask

  // Sends n bytes, counts edges from the opcode edge to the done pulse
  task automatic run(input int n, input logic [7:0] b0, input logic [7:0] b1,
                     input logic [7:0] b2, input logic [2:0] cyc);
    logic [7:0] b [3];
    int         i;
    int         k;
    logic       tk;
    logic       seen;
    logic       low;
    b = '{b0, b1, b2};
    i = 0;
    k = 0;
    seen = 1'b0;
    low = 1'b0;
    @(posedge ref_clk);
    byte_valid <= 1'b1;
    byte_data  <= b0;
    repeat (40) begin
      @(negedge ref_clk);
      if (done_ff === 1'b1) begin
        seen = 1'b1;
        break;
      end
      // Once every byte is in, ready must be seen low at least once before the done cycle
      if (i == n && byte_ready_ff === 1'b0) low = 1'b1;
      tk = (byte_ready_ff === 1'b1) && (i < n);
      @(posedge ref_clk);
      if (i > 0) k++;
      if (tk) begin
        i++;
        if (i < n) byte_data <= b[i];
        else byte_valid <= 1'b0;
      end
    end
    chk8("done_seen", 8'h01, {7'h00, seen});
    chk8($sformatf("cycles_op_%h", b0), {5'h00, cyc}, 8'(k + 1));
    chk8("ready_low", 8'h01, {7'h00, low});
    chk8("ready_done", 8'h01, {7'h00, byte_ready_ff});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_work_moves;
    run(2, 8'h0C, 8'h10, 8'h00, CYC_4);
    rd_chk(8'hC0, 8'h10);
    wr(8'hC0, 8'h01);
    run(2, 8'h19, 8'h05, 8'h00, CYC_4);
    rd_chk(8'h05, 8'h0A);
    rd_chk(8'hC1, 8'h0A);
    run(2, 8'h28, 8'h01, 8'h00, CYC_4);
    rd_chk(8'hC2, 8'h20);
    run(2, OP_CP_IWW, 8'h01, 8'h00, CYC_4);
    rd_chk(8'h01, 8'h0A);
    run(2, OP_CP_WIW, 8'h20, 8'h00, CYC_4);
    rd_chk(8'hC2, 8'h0A);
    rd_chk(8'hC0, 8'h01);
  endtask

  task automatic t_full_moves;
    run(3, OP_CP_RR, 8'h01, 8'h00, CYC_6);
    rd_chk(8'h00, 8'h0A);
    rd_chk(8'h01, 8'h0A);
    run(3, OP_CP_RIR, 8'h02, 8'h06, CYC_6);
    rd_chk(8'h06, 8'hFF);
    run(3, OP_CP_RIM, 8'h07, 8'h5A, CYC_6);
    rd_chk(8'h07, 8'h5A);
    run(3, OP_CP_IRIM, 8'h07, 8'h33, CYC_6);
    rd_chk(8'h5A, 8'h33);
    rd_chk(8'h07, 8'h5A);
    run(3, OP_CP_IRR, 8'h05, 8'h07, CYC_6);
    rd_chk(8'h5A, 8'h0A);
  endtask

  // Offset plus index register lands on a register away from both
  task automatic t_indexed;
    run(3, OP_CP_WX, 8'h31, 8'h30, CYC_6);
    rd_chk(8'hC3, 8'hFF);
    run(3, OP_CP_XW, 8'h10, 8'h30, CYC_6);
    rd_chk(8'h31, 8'h0A);
  endtask

  task automatic t_bit_moves;
    wr(8'hC0, 8'h06);
    wr(8'h08, 8'h05);
    run(3, OP_BIT, 8'h01, 8'h08, CYC_6);
    rd_chk(8'h08, 8'h04);
    run(3, OP_BIT, 8'h04, 8'h08, CYC_6);
    rd_chk(8'hC0, 8'h07);
    wr(8'hC5, 8'h01);
    run(3, OP_BIT, 8'h5F, 8'h08, CYC_6);
    rd_chk(8'h08, 8'h84);
  endtask

  // Unknown opcode: no done pulse, unit back to idle and ready
  task automatic t_unknown;
    logic seen;
    seen = 1'b0;
    @(posedge ref_clk);
    byte_valid <= 1'b1;
    byte_data  <= 8'h00;
    @(posedge ref_clk);
    byte_valid <= 1'b0;
    repeat (6) begin
      @(negedge ref_clk);
      if (done_ff === 1'b1) seen = 1'b1;
    end
    chk8("unknown_done", 8'h00, {7'h00, seen});
    chk8("unknown_ready", 8'h01, {7'h00, byte_ready_ff});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    byte_valid = 1'b0;
    byte_data = 8'h00;
    work_base = 4'hC;
    flags_we = 1'b0;
    flags_wdata = 8'h00;
    ext_we = 1'b0;
    ext_addr = 8'h00;
    ext_wdata = 8'h00;
    err_total = 0;
    total_checks = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk8("flags_reset", FLAGS_RST, flags_ff);
    @(posedge ref_clk);
    flags_we    <= 1'b1;
    flags_wdata <= 8'hA5;
    @(posedge ref_clk);
    flags_we    <= 1'b0;
    wr(8'hC0, 8'h01);
    wr(8'hC1, 8'h0A);
    wr(8'h00, 8'h01);
    wr(8'h01, 8'h20);
    wr(8'h02, 8'h3A);
    wr(8'h3A, 8'hFF);
    t_unknown();
    t_work_moves();
    t_full_moves();
    t_indexed();
    t_bit_moves();
    @(negedge ref_clk);
    chk8("flags", 8'hA5, flags_ff);
    give_verdict();
  end
endmodule
`default_nettype wire
